// >>> jps_cfg.svh
// Address map, field layout, reset values and timing of the jog sequencer
`ifndef JPS_CFG_SVH
`define JPS_CFG_SVH
// Register byte offsets
`define JPS_A_CTRL     8'h00
`define JPS_A_COUNT    8'h04
`define JPS_A_WAIT     8'h08
`define JPS_A_STATUS   8'h0C
`define JPS_A_HIST     8'h20
// Control, count and wait fields
`define JPS_F_PAT      2:0
`define JPS_F_DIR      4
`define JPS_F_FUNC     9:8
`define JPS_F_COUNT    9:0
`define JPS_F_WAIT     13:0
// Status fields
`define JPS_F_ST       3:0
`define JPS_F_SVON     4
`define JPS_F_PEND     5
`define JPS_F_HALF     6
`define JPS_F_BLINK    7
`define JPS_F_HCNT     15:8
`define JPS_F_REP      25:16
// Reset values
`define JPS_RST_COUNT  10'h001
`define JPS_RST_WAIT   14'h0064
// Pattern codes
`define JPS_PAT_FR     3'h2
`define JPS_PAT_RF     3'h3
`define JPS_PAT_MAX    3'h5
// Clock rate and times in milliseconds
`define JPS_CLK_HZ     50000000
`define JPS_HZ_PER_KHZ 1000
`define JPS_HOLD_MS    10'h3E8
`define JPS_DONE_MS    14'h03E8
`define JPS_HIST_DEPTH 8
`endif

// >>> jps_drive_model.sv
// Drive-side model that finishes moves and parameter restores
`timescale 1ns/1ns
module jps_drive_model #(
    parameter int DLY = 30
) (
    // Clock and reset
    input  logic                 mclk,
    input  logic                 sys_rst,
    // Commands from the sequencer
    input  jps_pkg::jps_motion_s motion,
    input  logic                 restore_start,
    // Completion pulses
    output logic                 motion_done,
    output logic                 restore_done
);
    import jps_pkg::*;
    int mv_cnt = 0;
    int rs_cnt = 0;
    // A move ends after a fixed travel time; abort or baseblock cancels it
    always @(posedge mclk) begin
        motion_done <= 1'b0;
        restore_done <= 1'b0;
        if (sys_rst || motion.move_abort || motion.baseblock) begin
            mv_cnt <= 0;
        end else if (motion.move_start) begin
            mv_cnt <= DLY;
        end else if (mv_cnt > 0) begin
            mv_cnt <= mv_cnt - 1;
            motion_done <= (mv_cnt == 1);
        end
        if (sys_rst) begin
            rs_cnt <= 0;
        end else if (restore_start) begin
            rs_cnt <= DLY;
        end else if (rs_cnt > 0) begin
            rs_cnt <= rs_cnt - 1;
            restore_done <= (rs_cnt == 1);
        end
    end
endmodule : jps_drive_model

// >>> jps_pkg.sv
// Shared types of the jog program sequencer
package jps_pkg;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_FUNC, ST_PJ_ENTRY, ST_SVON, ST_WAIT, ST_MOVE, ST_END,
        ST_INIT_ENTRY, ST_INIT_RUN, ST_INIT_DONE, ST_CLR_ENTRY, ST_CLR_DONE
    } jps_state_e;
    // Utility chosen for the keypad
    typedef enum logic [1:0] {FN_PROG_JOG, FN_RESTORE, FN_CLEAR} jps_func_e;
    // APB request and answer
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } jps_apb_req_s;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } jps_apb_rsp_s;
    // Keypad keys, high while pressed
    typedef struct packed {
        logic mode;
        logic up;
        logic down;
        logic data;
    } jps_keys_s;
    // Commands to the motion and servo logic
    typedef struct packed {
        logic servo_on;
        logic baseblock;
        logic move_start;
        logic move_abort;
        logic move_fwd;
        logic scale_up;
        logic ref_inhibit;
    } jps_motion_s;
    // Whole state of the sequencer
    typedef struct packed {
        jps_state_e   st;
        jps_func_e    fn;
        logic [2:0]   pat;
        logic [2:0]   run_pat;
        logic         dir_sel;
        logic [9:0]   count;
        logic [13:0]  wait_ms;
        logic [9:0]   rep;
        logic         half;
        logic [15:0]  ms_div;
        logic         ms_tick;
        logic [13:0]  timer;
        logic [9:0]   hold;
        jps_keys_s    k1;
        jps_keys_s    k2;
        jps_keys_s    kp;
        logic         ref1;
        logic         ref2;
        logic         ref_out;
        logic         pend;
        logic         hist_clr;
        logic         restore_start;
        logic         blink;
        jps_motion_s  mv;
        jps_apb_rsp_s rsp;
    } jps_state_s;
endpackage : jps_pkg

// >>> jps_sequencer.sv
// Jog program sequencer with restore and history-clear utilities
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`include "jps_cfg.svh"
// Functional notes
// - Patterns 0,1,4,5 with repeat count zero repeat without end.
// - Patterns 2 and 3 never repeat without end.
// - Unbounded repetition keeps the pattern's move sequence.
// - Mode/set ends unbounded repetition by turning the servo off.
// - Patterns 0 and 1 always move one way.
// - Direction select 1 makes scale count-up the forward way.
// - Mode/set in jog entry turns the servo on.
// - Key matching first direction starts motion after the wait time.
// - Mode/set during motion baseblocks and stops the motor.
// - Long data/shift hold in motion stops, returns to selection.
// - Finished program blinks end, then back to servo-on ready.
// - After finish, mode/set baseblocks; long hold returns to selection.
// - Restored values apply only after the next power cycle.
// - Mode/set starts restore; blink while busy, done blink one second.
// - Clear command erases every history entry.
// - History survives fault reset and power loss; only clear erases.
// - Mode/set in clear function erases, then blinks one second.
// - External pulse reference is blocked while jog runs.
// - Jog runs only when the drive is servo ready.
module jps_sequencer #(
    parameter int CYC_PER_MS = `JPS_CLK_HZ / `JPS_HZ_PER_KHZ,
    parameter int HIST_DEPTH = `JPS_HIST_DEPTH
) (
    // Clock and reset
    input  logic                  mclk,
    input  logic                  sys_rst,
    // APB register bus
    input  jps_pkg::jps_apb_req_s apb_req,
    output jps_pkg::jps_apb_rsp_s apb_rsp,
    // Keypad pins
    input  jps_pkg::jps_keys_s    keys,
    // Drive status
    input  logic                  servo_ready,
    input  logic                  motion_done,
    input  logic                  restore_done,
    input  logic                  fault_valid,
    input  logic [7:0]            fault_code,
    // External pulse reference
    input  logic                  pulse_ref_in,
    output logic                  pulse_ref_out,
    // Drive commands
    output jps_pkg::jps_motion_s  motion,
    output logic                  restore_start,
    // Display
    output jps_pkg::jps_state_e   disp_state,
    output logic                  disp_blink
);
    import jps_pkg::*;

    localparam int HW = $clog2(HIST_DEPTH + 1);
    localparam int HI = $clog2(HIST_DEPTH);

    jps_state_s    r;
    jps_state_s    n;
    logic [7:0]    hist [HIST_DEPTH];
    logic [HW-1:0] hist_cnt;
    logic          mode_ev;
    logic          up_ev;
    logic          dn_ev;
    logic          long_ev;

    // Patterns with a forward block and a reverse block
    function automatic logic is_pair(input logic [2:0] p);
        is_pair = (p == `JPS_PAT_FR) || (p == `JPS_PAT_RF);
    endfunction : is_pair

    // Patterns with two moves in each repetition
    function automatic logic is_alt(input logic [2:0] p);
        is_alt = (p > `JPS_PAT_RF) && (p <= `JPS_PAT_MAX);
    endfunction : is_alt

    // Key press edges from the synchronised keys
    assign mode_ev = r.k2.mode & ~r.kp.mode;
    assign up_ev   = r.k2.up & ~r.kp.up;
    assign dn_ev   = r.k2.down & ~r.kp.down;
    assign long_ev = r.k2.data && r.ms_tick &&
                     (r.hold == `JPS_HOLD_MS - 10'h001);

    // Next state of the whole block
    always_comb begin
        logic [7:0] off;
        logic       last;
        logic       inf;
        off  = apb_req.paddr - `JPS_A_HIST;
        last = (r.rep + 10'h001) == r.count;
        inf  = (r.count == '0) && !is_pair(r.run_pat);
        n = r;
        n.mv.move_start = 1'b0;
        n.mv.move_abort = 1'b0;
        n.restore_start = 1'b0;
        n.hist_clr      = 1'b0;
        // Key and pulse synchronisers
        n.k1   = keys;
        n.k2   = r.k1;
        n.kp   = r.k2;
        n.ref1 = pulse_ref_in;
        n.ref2 = r.ref1;
        // Millisecond enable
        n.ms_tick = 1'b0;
        if (r.ms_div == 16'(CYC_PER_MS - 1)) begin
            n.ms_div  = '0;
            n.ms_tick = 1'b1;
        end else begin
            n.ms_div = r.ms_div + 16'h0001;
        end
        // hold timer sticks at one second
        if (!r.k2.data) begin
            n.hold = '0;
        end else if (r.ms_tick && r.hold != `JPS_HOLD_MS) begin
            n.hold = r.hold + 10'h001;
        end
        // Wait and blink timer in milliseconds
        if (r.ms_tick && r.timer != '0) begin
            n.timer = r.timer - 14'h0001;
        end
        // APB answer one cycle into the access phase
        n.rsp.pready  = apb_req.psel && apb_req.penable && !r.rsp.pready;
        n.rsp.prdata  = '0;
        n.rsp.pslverr = 1'b0;
        if (n.rsp.pready) begin
            case (apb_req.paddr)
                `JPS_A_CTRL: begin
                    n.rsp.prdata[`JPS_F_PAT]  = r.pat;
                    n.rsp.prdata[`JPS_F_DIR]  = r.dir_sel;
                    n.rsp.prdata[`JPS_F_FUNC] = r.fn;
                end
                `JPS_A_COUNT: n.rsp.prdata[`JPS_F_COUNT] = r.count;
                `JPS_A_WAIT:  n.rsp.prdata[`JPS_F_WAIT] = r.wait_ms;
                `JPS_A_STATUS: begin
                    n.rsp.prdata[`JPS_F_ST]    = r.st;
                    n.rsp.prdata[`JPS_F_SVON]  = r.mv.servo_on;
                    n.rsp.prdata[`JPS_F_PEND]  = r.pend;
                    n.rsp.prdata[`JPS_F_HALF]  = r.half;
                    n.rsp.prdata[`JPS_F_BLINK] = r.blink;
                    n.rsp.prdata[`JPS_F_HCNT]  = 8'(hist_cnt);
                    n.rsp.prdata[`JPS_F_REP]   = r.rep;
                end
                default: begin
                    if (apb_req.paddr >= `JPS_A_HIST && off[1:0] == 2'h0 &&
                        int'(off[7:2]) < HIST_DEPTH) begin
                        n.rsp.prdata[7:0] = hist[off[HI+1:2]];
                    end else begin
                        n.rsp.pslverr = 1'b1;
                    end
                end
            endcase
        end
        // Register writes on the completing edge
        if (apb_req.psel && apb_req.penable && r.rsp.pready &&
            apb_req.pwrite) begin
            case (apb_req.paddr)
                `JPS_A_CTRL: begin
                    n.pat     = apb_req.pwdata[`JPS_F_PAT];
                    n.dir_sel = apb_req.pwdata[`JPS_F_DIR];
                    n.fn      = jps_func_e'(apb_req.pwdata[`JPS_F_FUNC]);
                end
                `JPS_A_COUNT: n.count = apb_req.pwdata[`JPS_F_COUNT];
                `JPS_A_WAIT:  n.wait_ms = apb_req.pwdata[`JPS_F_WAIT];
                default: ;
            endcase
        end
        if (r.mv.servo_on && (mode_ev || long_ev || !servo_ready)) begin
            n.mv.servo_on   = 1'b0;
            n.mv.baseblock  = 1'b1;
            n.mv.move_abort = (r.st == ST_MOVE);
            n.st            = long_ev ? ST_FUNC : ST_PJ_ENTRY;
        end else begin
            case (r.st)
                ST_FUNC: begin
                    if (long_ev) begin
                        case (r.fn)
                            FN_PROG_JOG: n.st = servo_ready ? ST_PJ_ENTRY
                                                            : ST_FUNC;
                            FN_RESTORE:  n.st = ST_INIT_ENTRY;
                            FN_CLEAR:    n.st = ST_CLR_ENTRY;
                            default:     n.st = ST_FUNC;
                        endcase
                    end
                end
                ST_PJ_ENTRY: begin
                    if (long_ev) begin
                        n.st = ST_FUNC;
                    end else if (mode_ev && servo_ready) begin
                        n.st           = ST_SVON;
                        n.mv.servo_on  = 1'b1;
                        n.mv.baseblock = 1'b0;
                    end
                end
                ST_SVON: begin
                    if ((r.pat[0] ? dn_ev : up_ev) &&
                        r.pat <= `JPS_PAT_MAX &&
                        !(is_pair(r.pat) && r.count == '0)) begin
                        n.st      = ST_WAIT;
                        n.timer   = r.wait_ms;
                        n.rep     = '0;
                        n.half    = 1'b0;
                        n.run_pat = r.pat;
                    end
                end
                ST_WAIT: begin
                    if (r.timer == '0) begin
                        n.st            = ST_MOVE;
                        n.mv.move_start = 1'b1;
                        n.mv.move_fwd   = ~(r.run_pat[0] ^ r.half);
                        n.mv.scale_up   = ~(r.run_pat[0] ^ r.half ^
                                            r.dir_sel) ^ 1'b1;
                    end
                end
                ST_MOVE: begin
                    if (motion_done) begin
                        n.st    = ST_WAIT;
                        n.timer = r.wait_ms;
                        if (is_alt(r.run_pat) && !r.half) begin
                            n.half = 1'b1;
                        end else if (!inf && last) begin
                            if (is_pair(r.run_pat) && !r.half) begin
                                n.half = 1'b1;
                                n.rep  = '0;
                            end else begin
                                n.st    = ST_END;
                                n.timer = `JPS_DONE_MS;
                            end
                        end else begin
                            n.rep  = r.rep + 10'h001;
                            n.half = is_pair(r.run_pat) & r.half;
                        end
                    end
                end
                ST_END: begin
                    if (r.timer == '0) begin
                        n.st = ST_SVON;
                    end
                end
                ST_INIT_ENTRY: begin
                    if (long_ev) begin
                        n.st = ST_FUNC;
                    end else if (mode_ev && !r.mv.servo_on) begin
                        n.st            = ST_INIT_RUN;
                        n.restore_start = 1'b1;
                        n.pend          = 1'b1;
                    end
                end
                ST_INIT_RUN: begin
                    if (restore_done) begin
                        n.st    = ST_INIT_DONE;
                        n.timer = `JPS_DONE_MS;
                    end
                end
                ST_INIT_DONE: begin
                    if (r.timer == '0) begin
                        n.st = ST_INIT_ENTRY;
                    end
                end
                ST_CLR_ENTRY: begin
                    if (long_ev) begin
                        n.st = ST_FUNC;
                    end else if (mode_ev) begin
                        n.st       = ST_CLR_DONE;
                        n.hist_clr = 1'b1;
                        n.timer    = `JPS_DONE_MS;
                    end
                end
                ST_CLR_DONE: begin
                    if (r.timer == '0) begin
                        n.st = ST_CLR_ENTRY;
                    end
                end
                default: n.st = ST_FUNC;
            endcase
        end
        n.mv.ref_inhibit = n.mv.servo_on;
        n.ref_out        = r.ref2 & ~n.mv.ref_inhibit;
        n.blink = (n.st == ST_END) || (n.st == ST_INIT_RUN) ||
                  (n.st == ST_INIT_DONE) || (n.st == ST_CLR_DONE);
    end

    // State register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            r              <= '0;
            r.count        <= `JPS_RST_COUNT;
            r.wait_ms      <= `JPS_RST_WAIT;
            r.mv.baseblock <= 1'b1;
        end else begin
            r <= n;
        end
    end

    always_ff @(posedge mclk) begin
        if (r.hist_clr) begin
            // A fault logged with the clear survives as the only entry
            hist_cnt <= HW'(fault_valid);
            for (int i = 0; i < HIST_DEPTH; i++) begin
                hist[i] <= '0;
            end
            if (fault_valid) begin
                hist[0] <= fault_code;
            end
        end else if (fault_valid) begin
            hist[0] <= fault_code;
            for (int i = 1; i < HIST_DEPTH; i++) begin
                hist[i] <= hist[i-1];
            end
            if (int'(hist_cnt) < HIST_DEPTH) begin
                hist_cnt <= hist_cnt + HW'(1);
            end
        end
    end

    // Outputs straight from the state register
    assign apb_rsp       = r.rsp;
    assign motion        = r.mv;
    assign pulse_ref_out = r.ref_out;
    assign restore_start = r.restore_start;
    assign disp_state    = r.st;
    assign disp_blink    = r.blink;

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_stop_req;
        r.st == ST_MOVE && mode_ev && !long_ev;
    endsequence
    sequence s_clr_req;
        r.st == ST_CLR_ENTRY && mode_ev && !long_ev;
    endsequence

    property p_endless;
        r.st == ST_MOVE && motion_done && r.mv.servo_on && servo_ready &&
        !mode_ev && !long_ev && r.count == '0 && !is_pair(r.run_pat)
        |=> r.st == ST_WAIT;
    endproperty
    a_endless: assert property (p_endless)
        else $error("endless run finished");
    property p_no_endless;
        r.st == ST_SVON && servo_ready && !mode_ev && !long_ev &&
        is_pair(r.pat) && r.count == '0 |=> r.st == ST_SVON;
    endproperty
    a_no_endless: assert property (p_no_endless)
        else $error("pair pattern started with zero count");
    property p_one_way;
        r.mv.move_start && r.run_pat < `JPS_PAT_FR
        |-> r.mv.move_fwd == !r.run_pat[0];
    endproperty
    a_one_way: assert property (p_one_way)
        else $error("single direction pattern reversed");
    property p_scale;
        r.mv.move_start |-> r.mv.scale_up == (r.mv.move_fwd ~^ $past(r.dir_sel));
    endproperty
    a_scale: assert property (p_scale)
        else $error("scale direction wrong");
    property p_svon;
        r.st == ST_PJ_ENTRY && mode_ev && !long_ev && servo_ready
        |=> r.mv.servo_on && !r.mv.baseblock ##1 r.mv.servo_on || !servo_ready;
    endproperty
    a_svon: assert property (p_svon)
        else $error("servo not on after mode key");
    property p_wait_gate;
        r.st == ST_WAIT && r.timer != '0 |=> !r.mv.move_start;
    endproperty
    a_wait_gate: assert property (p_wait_gate)
        else $error("move started before wait time");
    property p_stop;
        s_stop_req |=> !r.mv.servo_on && r.mv.baseblock && r.mv.move_abort
        ##1 !r.mv.move_abort;
    endproperty
    a_stop: assert property (p_stop)
        else $error("motion not stopped by mode key");
    property p_long_stop;
        r.st == ST_MOVE && long_ev |=> r.st == ST_FUNC && !r.mv.servo_on;
    endproperty
    a_long_stop: assert property (p_long_stop)
        else $error("long hold did not stop motion");
    property p_clear;
        s_clr_req |=> r.hist_clr && r.blink
        ##1 hist_cnt == HW'($past(fault_valid));
    endproperty
    a_clear: assert property (p_clear)
        else $error("history not cleared");
    property p_inhibit;
        r.mv.ref_inhibit |-> !r.ref_out;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("pulse reference passed during jog");
endmodule : jps_sequencer

// >>> testbench.sv
// Self-checking bench of the jog program sequencer
`timescale 1ns/1ns
`include "jps_cfg.svh"
module testbench;
    import jps_pkg::*;
    localparam int CPM = 5;
    localparam int LONG = 1100 * CPM;
    localparam logic [3:0] KM = 4'h8;
    localparam logic [3:0] KU = 4'h4;
    localparam logic [3:0] KD = 4'h2;
    localparam logic [3:0] KL = 4'h1;
    logic         mclk = 1'b0;
    logic         sys_rst = 1'b1;
    jps_apb_req_s apb_req = '0;
    jps_apb_rsp_s apb_rsp;
    jps_keys_s    keys = '0;
    logic         servo_ready = 1'b1;
    logic         fault_valid = 1'b0;
    logic [7:0]   fault_code = 8'h00;
    logic         pulse_ref_in = 1'b1;
    logic         pulse_ref_out, motion_done, restore_done, restore_start;
    jps_motion_s  motion;
    jps_state_e   disp_state;
    logic         disp_blink, er, ab_seen = 1'b0;
    logic [31:0]  rd;
    logic [1:0]   mv_q[$];
    int           n_errors = 0;
    int           n_compared = 0;
    int           cyc = 0;
    int           i;

    jps_sequencer #(.CYC_PER_MS(CPM)) jps_sequencer_inst (.mclk(mclk),
        .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .keys(keys), .servo_ready(servo_ready), .motion_done(motion_done),
        .restore_done(restore_done), .fault_valid(fault_valid),
        .fault_code(fault_code), .pulse_ref_in(pulse_ref_in),
        .pulse_ref_out(pulse_ref_out), .motion(motion),
        .restore_start(restore_start), .disp_state(disp_state),
        .disp_blink(disp_blink));
    jps_drive_model jps_drive_model_inst (.mclk(mclk), .sys_rst(sys_rst),
        .motion(motion), .restore_start(restore_start),
        .motion_done(motion_done), .restore_done(restore_done));

    // Clock and hang guard
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // Log each move as {forward, scale up} and note aborts
    always @(posedge mclk) begin
        if (motion.move_start === 1'b1) begin
            mv_q.push_back({motion.move_fwd, motion.scale_up});
        end
        if (motion.move_abort === 1'b1) begin
            ab_seen <= 1'b1;
        end
    end

    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    task chk(input logic [39:0] got, input logic [39:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // APB transfer held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req <= '0;
        @(posedge mclk);
    endtask : apb

    // Press keys at least 8 cycles, then up to n more or until state t shows
    task key(input logic [3:0] m, input int n, input jps_state_e t);
        int k;
        keys <= m;
        repeat (8) @(posedge mclk);
        for (k = 0; k < n && disp_state !== t; k++) @(posedge mclk);
        keys <= '0;
        repeat (6) @(posedge mclk);
        chk(disp_state, t);
    endtask : key

    task wait_st(input jps_state_e s, input int n);
        int k;
        for (k = 0; k < n && disp_state !== s; k++) @(posedge mclk);
    endtask : wait_st

    task log_fault(input logic [7:0] c);
        fault_code <= c;
        fault_valid <= 1'b1;
        @(posedge mclk);
        fault_valid <= 1'b0;
        @(posedge mclk);
    endtask : log_fault

    task s_endless;
        servo_ready <= 1'b0;
        keys <= KL;
        repeat (LONG) @(posedge mclk);
        keys <= '0;
        repeat (6) @(posedge mclk);
        chk(disp_state, ST_FUNC);
        servo_ready <= 1'b1;
        apb(1'b1, `JPS_A_COUNT, 32'h0);
        apb(1'b1, `JPS_A_WAIT, 32'h5);
        key(KL, LONG, ST_PJ_ENTRY);
        key(KM, 8, ST_SVON);
        chk({motion.servo_on, motion.baseblock, motion.ref_inhibit}, 3'h5);
        chk(pulse_ref_out, 1'b0);
        key(KD, 8, ST_SVON);
        mv_q = {};
        key(KU, 8, ST_WAIT);
        chk(mv_q.size(), 0);
        wait_st(ST_END, 600);
        chk(mv_q.size() >= 5, 1'b1);
        for (i = 0; i < 5; i++) chk(mv_q[i], 2'h2);
        wait_st(ST_WAIT, 100);
        wait_st(ST_MOVE, 100);
        key(KM, 8, ST_PJ_ENTRY);
        chk({motion.servo_on, motion.baseblock, ab_seen}, 3'h3);
    endtask : s_endless

    task s_two_way;
        apb(1'b1, `JPS_A_CTRL, 32'h12);
        key(KM, 8, ST_SVON);
        key(KU, 8, ST_SVON);
        apb(1'b1, `JPS_A_COUNT, 32'h1);
        mv_q = {};
        key(KU, 8, ST_WAIT);
        wait_st(ST_END, 400);
        chk({disp_state, disp_blink}, {ST_END, 1'b1});
        chk({mv_q.size(), mv_q[0], mv_q[1]}, {32'd2, 4'hC});
        wait_st(ST_SVON, LONG);
        chk(disp_state, ST_SVON);
        key(KM, 8, ST_PJ_ENTRY);
        chk(motion.baseblock, 1'b1);
    endtask : s_two_way

    task s_repeat_exit;
        apb(1'b1, `JPS_A_CTRL, 32'h5);
        apb(1'b1, `JPS_A_COUNT, 32'h0);
        key(KM, 8, ST_SVON);
        key(KU, 8, ST_SVON);
        mv_q = {};
        key(KD, 8, ST_WAIT);
        apb(1'b1, `JPS_A_WAIT, 32'h0);
        wait_st(ST_END, 400);
        for (i = 0; i < 4; i++) chk(mv_q[i][1], i % 2 == 1);
        key(KL, LONG, ST_FUNC);
        chk(motion.servo_on, 1'b0);
    endtask : s_repeat_exit

    // restore asked only from function selection, servo off
    task s_restore;
        apb(1'b1, `JPS_A_CTRL, 32'h100);
        key(KL, LONG, ST_INIT_ENTRY);
        apb(1'b1, `JPS_A_COUNT, 32'h7);
        key(KM, 8, ST_INIT_RUN);
        chk(disp_blink, 1'b1);
        wait_st(ST_INIT_DONE, 100);
        apb(1'b0, `JPS_A_STATUS, 32'h0);
        chk(rd[5], 1'b1);
        apb(1'b0, `JPS_A_COUNT, 32'h0);
        chk(rd, 32'h7);
        repeat (900 * CPM) @(posedge mclk);
        chk({disp_state, disp_blink}, {ST_INIT_DONE, 1'b1});
        wait_st(ST_INIT_ENTRY, 200 * CPM);
        chk(disp_state, ST_INIT_ENTRY);
        key(KL, LONG, ST_FUNC);
    endtask : s_restore

    task s_clear;
        apb(1'b1, `JPS_A_CTRL, 32'h200);
        key(KL, LONG, ST_CLR_ENTRY);
        key(KM, 8, ST_CLR_DONE);
        chk(disp_blink, 1'b1);
        log_fault(8'hA1);
        log_fault(8'hA2);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        apb(1'b0, `JPS_A_HIST, 32'h0);
        chk(rd, 32'hA2);
        apb(1'b0, `JPS_A_HIST + 8'h04, 32'h0);
        chk(rd, 32'hA1);
        apb(1'b1, `JPS_A_CTRL, 32'h200);
        key(KL, LONG, ST_CLR_ENTRY);
        key(KM, 8, ST_CLR_DONE);
        apb(1'b0, `JPS_A_STATUS, 32'h0);
        chk(rd[15:8], 8'h00);
        apb(1'b0, `JPS_A_HIST, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `JPS_A_HIST + 8'h04, 32'h0);
        chk(rd, 32'h0);
        wait_st(ST_CLR_ENTRY, LONG);
        chk(disp_state, ST_CLR_ENTRY);
    endtask : s_clear

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(pulse_ref_out, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chk({er, rd}, 33'h100000000);
        s_endless();
        s_two_way();
        s_repeat_exit();
        s_restore();
        s_clear();
        tally_and_finish();
    end
endmodule : testbench
